//--- design/compositor_consts.svh
`ifndef COMPOSITOR_CONSTS_SVH
`define COMPOSITOR_CONSTS_SVH

// Clock rate of ref_clk
`define REF_CLK_MHZ 25
`define NUM_LAYERS 5
`define COORD_W 11
`define ADDR_W 32
`define WORD_W 32
`define WORD_BYTES 4

// Panel timing, in pixel clocks and lines
`define H_ACTIVE 640
`define H_FRONT 16
`define H_SYNC 96
`define H_BACK 48
`define V_ACTIVE 480
`define V_FRONT 10
`define V_SYNC 2
`define V_BACK 33

// Colour lookup entry layout
`define PAL_ENTRIES 256
`define PAL_W 24
`define PAL_COLOUR_LSB 6
`define PAL_ALPHA_LSB 0
`define ALPHA_OPAQUE 6'h3F
`define ALPHA_CLEAR 6'h00

`endif

//--- design/compositor_pkg.sv
`include "compositor_consts.svh"

package compositor_pkg;

    typedef struct packed {
        logic [5:0] r;
        logic [5:0] g;
        logic [5:0] b;
    } rgb_t;

    typedef struct packed {
        logic enable;
        logic [`ADDR_W-1:0] base;
        logic [5:0] alpha;
        logic [`COORD_W-1:0] x;
        logic [`COORD_W-1:0] y;
        logic [`COORD_W-1:0] w;
        logic [`COORD_W-1:0] h;
    } layer_cfg_t;

    typedef struct packed {
        logic req;
        logic [`ADDR_W-1:0] addr;
    } mem_cmd_t;

    typedef struct packed {
        logic de;
        logic hsync_n;
        logic vsync_n;
        rgb_t rgb;
    } video_out_t;

endpackage

//--- design/layer_fetch.sv
`timescale 1ns/1ps
`default_nettype none

module layer_fetch
    import compositor_pkg::*;
#(
    parameter int BPP = 16
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic enable,
    input wire logic [`ADDR_W-1:0] base,
    input wire logic restart,
    input wire logic take,
    output mem_cmd_t mem_cmd,
    input wire logic mem_ack,
    input wire logic [`WORD_W-1:0] mem_rdata,
    output logic [15:0] pix,
    output logic pix_ok
);
    localparam int PPW = `WORD_W / BPP;
    localparam logic [1:0] LAST_IDX = 2'(PPW - 1);

    generate
        if (BPP != 16 && BPP != 8) begin : g_bad_bpp
            $error("layer_fetch supports 8 or 16 bits per pixel");
        end
    endgenerate

    logic [`WORD_W-1:0] cur;
    logic [`WORD_W-1:0] nxt;
    logic cur_v;
    logic nxt_v;
    logic [1:0] idx;

    wire pop = take && cur_v;
    wire free = !cur_v || (pop && idx == LAST_IDX);
    wire [7:0] byte_sel = cur[{idx, 3'b000} +: 8];
    wire [15:0] half_sel = idx[0] ? cur[31:16] : cur[15:0];

    // Lowest address holds the leftmost pixel
    assign pix = (BPP == 16) ? half_sel : {8'h00, byte_sel};
    assign pix_ok = cur_v;

    // Two words per layer so a fetch overlaps the word being shown
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cur <= 32'h00000000;
            nxt <= 32'h00000000;
            cur_v <= 1'b0;
            nxt_v <= 1'b0;
            idx <= 2'h0;
        end else if (ce) begin
            if (restart) begin
                cur_v <= 1'b0;
                nxt_v <= 1'b0;
                idx <= 2'h0;
            end else if (free) begin
                idx <= 2'h0;
                if (nxt_v) begin
                    cur <= nxt;
                    cur_v <= 1'b1;
                    nxt_v <= 1'b0;
                end else begin
                    // Only answered words enter; idle data lines are junk
                    if (mem_ack) begin
                        cur <= mem_rdata;
                    end
                    cur_v <= mem_ack;
                end
            end else begin
                if (pop) begin
                    idx <= idx + 2'h1;
                end
                if (mem_ack) begin
                    nxt <= mem_rdata;
                    nxt_v <= 1'b1;
                end
            end
        end
    end

    // One word in flight at most; the address steps a word per reply
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mem_cmd <= '0;
        end else if (ce) begin
            if (restart) begin
                mem_cmd.req <= 1'b0;
                // Low bits dropped: bases are word aligned
                mem_cmd.addr <= {base[`ADDR_W-1:2], 2'b00};
            end else if (mem_cmd.req) begin
                if (mem_ack) begin
                    mem_cmd.req <= 1'b0;
                    mem_cmd.addr <= mem_cmd.addr + `ADDR_W'(`WORD_BYTES);
                end
            end else if (enable && !nxt_v && !(free && cur_v)) begin
                mem_cmd.req <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

//--- design/layered_lcd_frame_compositor.sv
// How it works
// - Layers one and two carry 16-bit pixels in 5-6-5 red-green-blue order.
// - A 16-bit layer advances two bytes of frame buffer per shown pixel.
// - Layers three to five use each 8-bit pixel as a 256-entry table index.
// - Each table entry is an 18-bit colour plus a 6-bit pixel alpha.
// - Table contents are fixed at build time with no run-time write path.
// - Every 8-bit layer owns a separate table, all filled alike.
// - An 8-bit layer advances one byte of frame buffer per shown pixel.
// - An interrupt request is raised at the end of every shown frame.
// - The video layer blends with one layer-wide alpha.
// - Drawing layers blend with pixel alpha times layer alpha.
// - Five layers composite into one image, with picture-in-picture.
// - The pixel side runs on a 25 MHz pixel clock.
// - Layers above the backdrop may show a small buffer anywhere on screen.
`timescale 1ns/1ps
`default_nettype none

module layered_lcd_frame_compositor
    import compositor_pkg::*;
#(
    parameter int H_ACTIVE = `H_ACTIVE,
    parameter int H_FRONT = `H_FRONT,
    parameter int H_SYNC = `H_SYNC,
    parameter int H_BACK = `H_BACK,
    parameter int V_ACTIVE = `V_ACTIVE,
    parameter int V_FRONT = `V_FRONT,
    parameter int V_SYNC = `V_SYNC,
    parameter int V_BACK = `V_BACK
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ce,
    input wire layer_cfg_t cfg [`NUM_LAYERS],
    output mem_cmd_t mem_cmd [`NUM_LAYERS],
    input wire logic mem_ack [`NUM_LAYERS],
    input wire logic [`WORD_W-1:0] mem_rdata [`NUM_LAYERS],
    output video_out_t video,
    output logic frame_irq
);
    localparam int NL = `NUM_LAYERS;
    localparam int CW = `COORD_W;
    localparam int H_TOTAL = H_ACTIVE + H_FRONT + H_SYNC + H_BACK;
    localparam int V_TOTAL = V_ACTIVE + V_FRONT + V_SYNC + V_BACK;
    localparam logic [CW-1:0] HA = CW'(H_ACTIVE);
    localparam logic [CW-1:0] VA = CW'(V_ACTIVE);
    localparam logic [CW-1:0] HT_LAST = CW'(H_TOTAL - 1);
    localparam logic [CW-1:0] VT_LAST = CW'(V_TOTAL - 1);
    localparam logic [CW-1:0] HS_ON = CW'(H_ACTIVE + H_FRONT);
    localparam logic [CW-1:0] HS_OFF = CW'(H_ACTIVE + H_FRONT + H_SYNC);
    localparam logic [CW-1:0] VS_ON = CW'(V_ACTIVE + V_FRONT);
    localparam logic [CW-1:0] VS_OFF = CW'(V_ACTIVE + V_FRONT + V_SYNC);

    generate
        if (H_TOTAL >= 2 ** CW || V_TOTAL >= 2 ** CW) begin : g_bad_size
            $error("panel timing exceeds coordinate width");
        end
        if (H_ACTIVE < 1 || V_ACTIVE < 1) begin : g_bad_active
            $error("active area must be at least one pixel");
        end
    endgenerate

    // Build-time colour table: 3-3-2 colour ramp, index 0 transparent
    function automatic logic [`PAL_W-1:0] pal_init(input logic [7:0] n);
        logic [17:0] col;
        logic [5:0] a;
        col = {n[7:5], n[7:5], n[4:2], n[4:2], n[1:0], n[1:0], n[1:0]};
        a = (n == 8'h00) ? `ALPHA_CLEAR : `ALPHA_OPAQUE;
        pal_init = {col, a};
    endfunction

    // One channel: alpha 0..63 stretched to 0..64 so 63 is fully opaque
    function automatic logic [5:0] mix(input logic [5:0] dst,
                                      input logic [5:0] src,
                                      input logic [5:0] a);
        logic [6:0] a7;
        logic [12:0] sum;
        a7 = {1'b0, a} + {6'h00, a[5]};
        sum = 13'(src * a7) + 13'(dst * (7'h40 - a7));
        mix = sum[11:6];
    endfunction

    function automatic rgb_t blend(input rgb_t dst, input rgb_t src,
                                   input logic [5:0] a);
        blend.r = mix(dst.r, src.r, a);
        blend.g = mix(dst.g, src.g, a);
        blend.b = mix(dst.b, src.b, a);
    endfunction

    // 5-6-5 widened to six bits per primary
    function automatic rgb_t from565(input logic [15:0] p);
        from565.r = {p[15:11], p[15]};
        from565.g = p[10:5];
        from565.b = {p[4:0], p[4]};
    endfunction

    logic [CW-1:0] hcnt;
    logic [CW-1:0] vcnt;

    wire h_end = hcnt == HT_LAST;
    wire de0 = hcnt < HA && vcnt < VA;
    wire frame_end = de0 && hcnt == HA - 1'b1 && vcnt == VA - 1'b1;
    wire hs0_n = !(hcnt >= HS_ON && hcnt < HS_OFF);
    wire vs0_n = !(vcnt >= VS_ON && vcnt < VS_OFF);

    // Raster counters, the frame walks the full blanking
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hcnt <= '0;
            vcnt <= '0;
        end else if (ce) begin
            hcnt <= h_end ? '0 : hcnt + 1'b1;
            if (h_end) begin
                vcnt <= (vcnt == VT_LAST) ? '0 : vcnt + 1'b1;
            end
        end
    end

    logic [15:0] pix0 [NL];
    logic pix_ok [NL];
    logic shown [NL];
    logic take [NL];

    // Per-layer window and fetch; refill starts right after the last active pixel
    genvar i;
    generate
        for (i = 0; i < NL; i++) begin : g_layer
            wire [CW:0] x_end = {1'b0, cfg[i].x} + {1'b0, cfg[i].w};
            wire [CW:0] y_end = {1'b0, cfg[i].y} + {1'b0, cfg[i].h};
            wire in_win = hcnt >= cfg[i].x && {1'b0, hcnt} < x_end
                       && vcnt >= cfg[i].y && {1'b0, vcnt} < y_end;
            // Backdrop always spans the whole screen
            assign shown[i] = cfg[i].enable && (i == 0 || in_win);
            assign take[i] = de0 && shown[i];

            layer_fetch #(
                .BPP(i < 2 ? 16 : 8)
            ) u_fetch (
                .ref_clk(ref_clk),
                .reset(reset),
                .ce(ce),
                .enable(cfg[i].enable),
                .base(cfg[i].base),
                .restart(frame_end),
                .take(take[i]),
                .mem_cmd(mem_cmd[i]),
                .mem_ack(mem_ack[i]),
                .mem_rdata(mem_rdata[i]),
                .pix(pix0[i]),
                .pix_ok(pix_ok[i])
            );
        end
    endgenerate

    logic [15:0] pix1 [NL];
    logic vis1 [NL];
    logic [`PAL_W-1:0] pal_q [NL];
    logic de1;
    logic hs1_n;
    logic vs1_n;

    // Stage one: capture pixels; starved or hidden pixels turn clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            de1 <= 1'b0;
            hs1_n <= 1'b1;
            vs1_n <= 1'b1;
        end else if (ce) begin
            de1 <= de0;
            hs1_n <= hs0_n;
            vs1_n <= vs0_n;
        end
    end

    generate
        for (i = 0; i < NL; i++) begin : g_stage1
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    pix1[i] <= 16'h0000;
                    vis1[i] <= 1'b0;
                end else if (ce) begin
                    pix1[i] <= pix0[i];
                    vis1[i] <= take[i] && pix_ok[i];
                end
            end
            if (i < 2) begin : g_no_pal
                assign pal_q[i] = '0;
            end else begin : g_pal
                // Private ROM per drawing layer, no write port
                logic [`PAL_W-1:0] pal [`PAL_ENTRIES];
                logic [`PAL_W-1:0] q;
                initial begin
                    for (int n = 0; n < `PAL_ENTRIES; n++) begin
                        pal[n] = pal_init(8'(n));
                    end
                end
                always_ff @(posedge ref_clk) begin
                    if (ce) begin
                        q <= pal[pix0[i][7:0]];
                    end
                end
                assign pal_q[i] = q;
            end
        end
    endgenerate

    rgb_t layer_rgb [NL];
    logic [5:0] layer_a [NL];
    rgb_t acc [NL];

    // Colour and effective alpha of every layer
    generate
        for (i = 0; i < NL; i++) begin : g_colour
            if (i < 2) begin : g_direct
                assign layer_rgb[i] = from565(pix1[i]);
                assign layer_a[i] = !vis1[i] ? `ALPHA_CLEAR
                                  : (i == 0) ? `ALPHA_OPAQUE
                                  : cfg[i].alpha;
            end else begin : g_indexed
                wire [5:0] pa = pal_q[i][`PAL_ALPHA_LSB +: 6];
                wire [6:0] la7 = {1'b0, cfg[i].alpha}
                               + {6'h00, cfg[i].alpha[5]};
                wire [12:0] prod = 13'(pa * la7);
                assign layer_rgb[i] = pal_q[i][`PAL_COLOUR_LSB +: 18];
                assign layer_a[i] = vis1[i] ? prod[11:6]
                                  : `ALPHA_CLEAR;
            end
        end
    endgenerate

    // Bottom-up chain over a black floor
    generate
        for (i = 0; i < NL; i++) begin : g_blend
            if (i == 0) begin : g_floor
                assign acc[i] = blend('0, layer_rgb[i], layer_a[i]);
            end else begin : g_over
                assign acc[i] = blend(acc[i-1], layer_rgb[i],
                                      layer_a[i]);
            end
        end
    endgenerate

    // Stage two: registered panel outputs and frame-end pulse
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            video <= '{de: 1'b0, hsync_n: 1'b1, vsync_n: 1'b1, rgb: '0};
            frame_irq <= 1'b0;
        end else if (ce) begin
            video.de <= de1;
            video.hsync_n <= hs1_n;
            video.vsync_n <= vs1_n;
            video.rgb <= de1 ? acc[NL-1] : '0;
            frame_irq <= frame_end;
        end
    end

endmodule

`default_nettype wire

//--- testbench/compositor_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "compositor_consts.svh"

module compositor_props
    import compositor_pkg::*;
#(
    parameter int H_ACTIVE = 8,
    parameter int H_FRONT = 2,
    parameter int H_SYNC = 2,
    parameter int H_BACK = 2,
    parameter int V_ACTIVE = 4,
    parameter int V_FRONT = 2,
    parameter int V_SYNC = 2,
    parameter int V_BACK = 2
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ce,
    input wire mem_cmd_t mem_cmd [`NUM_LAYERS],
    input wire logic mem_ack [`NUM_LAYERS],
    input wire video_out_t video,
    input wire logic frame_irq
);
    localparam int HT = H_ACTIVE + H_FRONT + H_SYNC + H_BACK;
    localparam int FT = HT * (V_ACTIVE + V_FRONT + V_SYNC + V_BACK);
    int hs_cnt;
    int vs_cnt;
    int fr_cnt;
    logic fr_seen;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Count in ce cycles only, since the raster stands still without ce
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hs_cnt <= 0;
            vs_cnt <= 0;
            fr_cnt <= 0;
            fr_seen <= 1'b0;
        end else if (ce) begin
            hs_cnt <= video.hsync_n ? 0 : hs_cnt + 1;
            vs_cnt <= video.vsync_n ? 0 : vs_cnt + 1;
            fr_cnt <= frame_irq ? 0 : fr_cnt + 1;
            fr_seen <= fr_seen | frame_irq;
        end
    end

    chk_blank_black: assert property (!video.de |-> video.rgb == 18'h0)
        else $error("colour not black outside active area");
    chk_hsync_width: assert property (
        $rose(video.hsync_n) |-> hs_cnt == H_SYNC)
        else $error("line sync pulse has wrong width");
    chk_vsync_width: assert property (
        $rose(video.vsync_n) |-> vs_cnt == V_SYNC * HT)
        else $error("frame sync pulse has wrong width");
    // A pulse held by a low clock enable is judged once, when ce returns
    chk_irq_period: assert property (
        frame_irq && ce && fr_seen |-> fr_cnt == FT - 1)
        else $error("frame interrupt spacing wrong");
    chk_irq_single: assert property (frame_irq && ce |=> !frame_irq)
        else $error("frame interrupt longer than one cycle");
    chk_freeze_hold: assert property (
        !ce |=> $stable(video) && $stable(frame_irq))
        else $error("outputs moved while clock enable low");

    // Memory port of every layer
    for (genvar i = 0; i < `NUM_LAYERS; i++) begin : g_mem
        chk_req_hold: assert property (
            mem_cmd[i].req && !(mem_ack[i] && ce) |=>
            mem_cmd[i].req && $stable(mem_cmd[i].addr) || frame_irq)
            else $error("read request dropped before answer");
        chk_addr_step: assert property (
            mem_cmd[i].req && mem_ack[i] && ce |=>
            mem_cmd[i].addr == $past(mem_cmd[i].addr) + 32'h4 || frame_irq)
            else $error("read address did not step by one word");
        chk_req_gap: assert property (
            mem_ack[i] && ce |=> !mem_cmd[i].req)
            else $error("no idle cycle after an answer");
    end
endmodule

bind layered_lcd_frame_compositor compositor_props #(
    .H_ACTIVE(H_ACTIVE), .H_FRONT(H_FRONT), .H_SYNC(H_SYNC),
    .H_BACK(H_BACK), .V_ACTIVE(V_ACTIVE), .V_FRONT(V_FRONT),
    .V_SYNC(V_SYNC), .V_BACK(V_BACK)
) props_inst (
    .ref_clk(ref_clk), .reset(reset), .ce(ce), .mem_cmd(mem_cmd),
    .mem_ack(mem_ack), .video(video), .frame_irq(frame_irq)
);
`default_nettype wire

//--- testbench/mem_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "compositor_consts.svh"

module mem_model
    import compositor_pkg::*;
(
    input wire logic ref_clk,
    input wire logic ce,
    input wire logic slow,
    input wire mem_cmd_t mem_cmd [`NUM_LAYERS],
    input wire logic [`WORD_W-1:0] mask [`NUM_LAYERS],
    output logic mem_ack [`NUM_LAYERS],
    output logic [`WORD_W-1:0] mem_rdata [`NUM_LAYERS]
);
    for (genvar i = 0; i < `NUM_LAYERS; i++) begin : g_lay
        logic wd;
        logic [7:0] a;
        logic [`WORD_W-1:0] last;
        // Byte at address A holds A, so pixel order shows in the data
        assign a = mem_cmd[i].addr[7:0];
        assign mem_ack[i] = mem_cmd[i].req && ce && (!slow || wd);
        // Idle data lines show the inverse of the last word, not a copy
        assign mem_rdata[i] = mem_ack[i] ? {a + 8'h03, a + 8'h02,
            a + 8'h01, a} & mask[i] : ~last;
        // Slow mode answers one cycle after the request shows
        always_ff @(posedge ref_clk) begin
            wd <= mem_cmd[i].req && !mem_ack[i];
            if (mem_ack[i]) last <= mem_rdata[i];
        end
    end
endmodule
`default_nettype wire

//--- testbench/layered_lcd_frame_compositor_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "compositor_consts.svh"

module layered_lcd_frame_compositor_tb
    import compositor_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset;
    logic ce;
    logic slow;
    layer_cfg_t cfg [`NUM_LAYERS];
    mem_cmd_t mem_cmd [`NUM_LAYERS];
    logic mem_ack [`NUM_LAYERS];
    logic [`WORD_W-1:0] mem_rdata [`NUM_LAYERS];
    logic [`WORD_W-1:0] mask [`NUM_LAYERS];
    video_out_t video;
    logic frame_irq;
    int failures = 0;
    int n_tests = 0;
    rgb_t frm [32];

    initial forever #20 ref_clk = ~ref_clk;

    // Raster shrunk to 8x4 active and 14-clock lines; vertical blanking
    // keeps its normal line counts, so a frame is 686 cycles
    layered_lcd_frame_compositor #(.H_ACTIVE(8), .H_FRONT(2), .H_SYNC(2),
        .H_BACK(2), .V_ACTIVE(4)
    ) layered_lcd_frame_compositor_inst (.ref_clk(ref_clk),
        .reset(reset), .ce(ce), .cfg(cfg), .mem_cmd(mem_cmd),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .video(video),
        .frame_irq(frame_irq));
    mem_model mem_model_inst (.ref_clk(ref_clk), .ce(ce), .slow(slow),
        .mem_cmd(mem_cmd), .mask(mask), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));

    task automatic check(input string what, input logic [17:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Sel 0 frame interrupt, 1 frame sync, 2 active pixel
    task automatic wait_for(input int sel);
        int n;
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit) begin
            @(negedge ref_clk);
            n++;
            hit = sel == 0 ? frame_irq === 1'b1 : sel == 1 ?
                video.vsync_n === 1'b0 : video.de === 1'b1;
            if (n > 1000) begin
                failures++;
                end_of_test();
            end
        end
    endtask

    // Setup only under reset, all layers off and full screen
    task automatic hold();
        @(posedge ref_clk);
        reset <= 1'b1;
        slow <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            cfg[i] <= '{1'b0, 32'h0, 6'h3F, 11'h0, 11'h0, 11'h8, 11'h4};
            mask[i] <= 32'hFFFF_FFFF;
        end
        // Let the defaults land before a scenario sets its own fields
        @(posedge ref_clk);
    endtask

    task automatic lay(input int i, input logic [31:0] b, input logic [5:0] a);
        cfg[i].enable <= 1'b1;
        cfg[i].base <= b;
        cfg[i].alpha <= a;
    endtask

    // First frame after reset is fetched from address 0, not the base, so the second is captured
    task automatic grab(input int idle);
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        if (idle > 0) begin
            repeat (5) @(posedge ref_clk);
            ce <= 1'b0;
            repeat (idle) @(posedge ref_clk);
            ce <= 1'b1;
        end
        wait_for(0);
        wait_for(1);
        for (int k = 0; k < 32; k++) begin
            wait_for(2);
            frm[k] = video.rgb;
        end
    endtask

    // Drawing layers blended bottom-up over black, window per layer
    function automatic rgb_t exp_pix(input int k);
        logic [7:0] n;
        int px, py, a;
        rgb_t o, s;
        px = k % 8;
        py = k / 8;
        o = 18'h0;
        for (int i = 2; i < 5; i++) begin
            n = cfg[i].base[7:0]
                + 8'((py - cfg[i].y) * cfg[i].w + px - cfg[i].x);
            if (cfg[i].enable && n != 8'h0
                && px >= cfg[i].x && py >= cfg[i].y
                && px < cfg[i].x + cfg[i].w && py < cfg[i].y + cfg[i].h) begin
                a = (63 * (cfg[i].alpha + cfg[i].alpha[5])) >> 6;
                a = a + a / 32;
                s = {n[7:5], n[7:5], n[4:2], n[4:2], n[1:0], n[1:0], n[1:0]};
                o.r = 6'((s.r * a + o.r * (64 - a)) >> 6);
                o.g = 6'((s.g * a + o.g * (64 - a)) >> 6);
                o.b = 6'((s.b * a + o.b * (64 - a)) >> 6);
            end
        end
        return o;
    endfunction

    // One drawing layer, opaque and then cleared by its layer alpha
    task automatic s_draw();
        for (int j = 0; j < 2; j++) begin
            hold();
            lay(2, 32'h0000_00F0, j ? 6'h00 : 6'h3F);
            grab(0);
            for (int k = 0; k < 32; k++)
                check("draw", frm[k], exp_pix(k));
        end
    endtask

    // Three drawing layers, top one half transparent
    task automatic s_stack();
        hold();
        lay(2, 32'h0000_0040, 6'h3F);
        lay(3, 32'h0000_00F0, 6'h3F);
        lay(4, 32'h0000_00E4, 6'h20);
        grab(0);
        for (int k = 0; k < 32; k++)
            check("stack", frm[k], exp_pix(k));
    endtask

    // Small window, slow memory and a clock enable pause
    task automatic s_pip();
        hold();
        slow <= 1'b1;
        lay(2, 32'h0000_0010, 6'h3F);
        cfg[2].x <= 11'h2;
        cfg[2].y <= 11'h1;
        cfg[2].w <= 11'h4;
        cfg[2].h <= 11'h2;
        grab(6);
        for (int k = 0; k < 32; k++)
            check("pip", frm[k], exp_pix(k));
    endtask

    // Black opaque video hides the backdrop; clear video shows it
    task automatic s_video();
        for (int j = 0; j < 2; j++) begin
            hold();
            mask[1] <= 32'h0;
            lay(0, 32'h0000_0100, 6'h3F);
            lay(1, 32'h0000_0200, j ? 6'h00 : 6'h3F);
            grab(0);
            for (int k = 0; k < 32; k++) begin
                if (j) check("back", 18'(|frm[k]), 18'h1);
                else check("video", frm[k], 18'h0);
            end
        end
    endtask

    initial begin
        reset = 1'b1;
        ce = 1'b1;
        slow = 1'b0;
        for (int i = 0; i < 5; i++) begin
            cfg[i] = '{1'b0, 32'h0, 6'h3F, 11'h0, 11'h0, 11'h8, 11'h4};
            mask[i] = 32'hFFFF_FFFF;
        end
        s_draw();
        s_stack();
        s_pip();
        s_video();
        end_of_test();
    end
endmodule
`default_nettype wire
